// [tcm_ctrl.v]
// Notes on behaviour
// R01 - timecode enters and leaves as decoded SMPTE frame words on code ports.
// R02 - off mode: no code embedded in recordings and none driven out.
// R03 - free run: counter always advances, code driven out except when idle mute holds it off.
// R04 - free run and record run accept preset load and reload.
// R05 - record run: counter advances only while recording, holds otherwise.
// R06 - entering record run freezes the counter at its last value.
// R07 - calendar mode runs always, loads from clock at start, change, entry.
// R08 - chase modes: counter follows the received code value.
// R09 - chase auto record: recording begins once valid external code appears.
// R10 - chase auto record: recording ends when external code ceases.
// R11 - idle mute on: no code driven out while recording is stopped.
// R12 - idle mute on: code still driven while recording or playback paused.
// R13 - idle mute unavailable in off and both chase modes.
// R14 - clock lock on: audio sample clock derived from incoming code.
// R15 - clock lock with no external code: fall back to internal audio clock.
// R16 - holdover on in chase: generate code while external code absent.
// R17 - clock lock and holdover unavailable outside chase modes.
// R18 - generator drift stays below half a frame per day.
// R19 - rates 23.976, 24, 25, 29.97, 30 non-drop and 29.97, 30 drop.
// R20 - auto record waits a set delay, 0 to 8 s, after code appears.
// R21 - counter holds hh:mm:ss:ff, frames wrap at rate and carry.
// R22 - code lost after one full frame period with no valid frame.
`include "tcm_defines.vh"
`default_nettype none
module tcm_ctrl #(
	parameter TENTH_CYC = `TCM_TENTH_NS / `TCM_CLK_NS
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire        ext_valid,
	input  wire [21:0] ext_tc,
	input  wire [21:0] rtc_tc,
	input  wire        rtc_changed,
	input  wire        rec_running,
	input  wire        rec_paused,
	output reg  [21:0] tc_out,
	output reg         tc_out_en,
	output reg         tc_frame,
	output reg         tc_embed,
	output reg         auto_rec,
	output reg         audio_clk_ext
);
	// ----------------------------------------
	// functions
	// ----------------------------------------
	function [4:0] rate_fps;
		input [2:0] r;
		begin
			case (r)
				`TCM_RATE_23976: rate_fps = 5'h18;
				`TCM_RATE_24:    rate_fps = 5'h18;
				`TCM_RATE_25:    rate_fps = 5'h19;
				default:         rate_fps = 5'h1E;
			endcase
		end
	endfunction

	function is_chase;
		input [2:0] m;
		begin
			is_chase = (m == `TCM_MODE_CHASE) || (m == `TCM_MODE_AUTO);
		end
	endfunction

	// one frame step with carry; drop modes skip frames 0 and 1 each
	// minute except every tenth
	function [21:0] tc_adv;
		input [21:0] t;
		input [4:0]  fps;
		input        dr;
		reg   [4:0]  ff;
		reg   [5:0]  ss;
		reg   [5:0]  mm;
		reg   [4:0]  hh;
		begin
			ff = t[`TCM_SS_LSB-1:`TCM_FF_LSB];
			ss = t[`TCM_MM_LSB-1:`TCM_SS_LSB];
			mm = t[`TCM_HH_LSB-1:`TCM_MM_LSB];
			hh = t[21:`TCM_HH_LSB];
			if (ff >= fps - 5'h01) // R21
			begin
				ff = 5'h00;
				if (ss >= 6'h3B)
				begin
					ss = 6'h00;
					if (mm >= 6'h3B)
					begin
						mm = 6'h00;
						hh = (hh >= 5'h17) ? 5'h00 : hh + 5'h01;
					end
					else
						mm = mm + 6'h01;
					if (dr && (mm % 6'h0A != 6'h00)) // R19
						ff = 5'h02;
				end
				else
					ss = ss + 6'h01;
			end
			else
				ff = ff + 5'h01;
			tc_adv = {hh, mm, ss, ff};
		end
	endfunction

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	reg  [10:0] ctrl;
	reg  [6:0]  delay;
	reg  [21:0] preset;
	reg  [7:0]  wr_addr;
	reg         wr_pend;
	wire        take = hsel && htrans[1] && hready;
	wire        wr_now = wr_pend;
	wire        cmd_wr = wr_now && (wr_addr == `TCM_OFS_CMD);
	wire        do_preset = cmd_wr && hwdata[`TCM_CMD_PRESET];
	wire        do_reload = cmd_wr && hwdata[`TCM_CMD_RELOAD];
	wire [7:0]  stat;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			ctrl <= `TCM_CTRL_RST;
			delay <= `TCM_DELAY_RST;
			preset <= 22'h000000;
			hrdata <= 32'h00000000;
		end
		else
		begin
			wr_pend <= take && hwrite;
			if (take)
				wr_addr <= haddr[7:0];
			if (wr_now && wr_addr == `TCM_OFS_CTRL)
				ctrl <= hwdata[10:0];
			if (wr_now && wr_addr == `TCM_OFS_DELAY)
				delay <= (hwdata[6:0] > `TCM_DELAY_MAX) ? `TCM_DELAY_MAX : hwdata[6:0]; // R20
			if (wr_now && wr_addr == `TCM_OFS_PRESET)
				preset <= hwdata[21:0];
			if (take && !hwrite)
			begin
				case (haddr[31:0])
					{24'h000000, `TCM_OFS_CTRL}:   hrdata <= {21'h000000, ctrl};
					{24'h000000, `TCM_OFS_DELAY}:  hrdata <= {25'h0000000, delay};
					{24'h000000, `TCM_OFS_PRESET}: hrdata <= {10'h000, preset};
					{24'h000000, `TCM_OFS_STATUS}: hrdata <= {24'h000000, stat};
					{24'h000000, `TCM_OFS_TC}:     hrdata <= {10'h000, tc_out};
					default:                       hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// effective settings
	// ----------------------------------------
	wire [2:0] mode = ctrl[`TCM_CTRL_MODE_LSB+2:`TCM_CTRL_MODE_LSB];
	wire [2:0] rate = ctrl[`TCM_CTRL_RATE_LSB+2:`TCM_CTRL_RATE_LSB];
	wire       chase = is_chase(mode);
	wire       mute_ok = ctrl[`TCM_CTRL_MUTE] && !chase && mode != `TCM_MODE_OFF; // R13
	wire       lock_ok = ctrl[`TCM_CTRL_CLKLOCK] && chase; // R17
	wire       hold_ok = ctrl[`TCM_CTRL_HOLD] && chase; // R17
	wire [4:0] fps = rate_fps(rate);
	wire       dropf = (rate == `TCM_RATE_2997D) || (rate == `TCM_RATE_30D);
	wire       pull = (rate == `TCM_RATE_23976) || (rate == `TCM_RATE_2997)
		|| (rate == `TCM_RATE_2997D);

	// ----------------------------------------
	// frame rate generator
	// ----------------------------------------
	// exact rational step per clock, so the generator has no long-term drift
	reg  [37:0] acc;
	wire [37:0] inc = {33'h000000000, fps} * (pull ? `TCM_MUL_PULL : `TCM_MUL_INT);
	wire [37:0] acc_sum = acc + inc;
	wire        tick = acc_sum >= `TCM_ACC_MOD;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			acc <= 38'h0000000000;
		else
			acc <= tick ? acc_sum - `TCM_ACC_MOD : acc_sum; // R18
	end

	// ----------------------------------------
	// external code presence
	// ----------------------------------------
	reg  [1:0] loss_cnt;
	reg        ext_present;
	reg  [21:0] ext_last;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			loss_cnt <= 2'h0;
			ext_present <= 1'b0;
			ext_last <= 22'h000000;
		end
		else if (ext_valid)
		begin
			loss_cnt <= 2'h0;
			ext_present <= 1'b1;
			ext_last <= ext_tc;
		end
		else if (tick)
		begin
			// two ticks always span at least one whole frame period
			if (loss_cnt == `TCM_LOSS_TICKS - 2'h1)
				ext_present <= 1'b0; // R22
			if (loss_cnt != `TCM_LOSS_TICKS)
				loss_cnt <= loss_cnt + 2'h1;
		end
	end

	// ----------------------------------------
	// auto record sequencer
	// ----------------------------------------
	localparam AR_IDLE = 3'b001;
	localparam AR_WAIT = 3'b010;
	localparam AR_REC  = 3'b100;
	reg [2:0]  ar_st;
	reg [6:0]  ar_tenths;
	reg [26:0] ar_cyc;
	wire       tenth_done = ar_cyc == TENTH_CYC - 1;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ar_st <= AR_IDLE;
			ar_tenths <= 7'h00;
			ar_cyc <= 27'h0000000;
			auto_rec <= 1'b0;
		end
		else if (mode != `TCM_MODE_AUTO)
		begin
			ar_st <= AR_IDLE;
			auto_rec <= 1'b0;
		end
		else
		begin
			case (ar_st)
				AR_IDLE:
				begin
					ar_tenths <= 7'h00;
					ar_cyc <= 27'h0000000;
					if (ext_present)
						ar_st <= AR_WAIT;
				end
				AR_WAIT:
				begin
					if (!ext_present)
						ar_st <= AR_IDLE;
					else if (ar_tenths >= delay)
					begin
						ar_st <= AR_REC; // R09 R20
						auto_rec <= 1'b1;
					end
					else if (tenth_done)
					begin
						ar_cyc <= 27'h0000000;
						ar_tenths <= ar_tenths + 7'h01;
					end
					else
						ar_cyc <= ar_cyc + 27'h0000001;
				end
				AR_REC:
				begin
					if (!ext_present)
					begin
						ar_st <= AR_IDLE; // R10
						auto_rec <= 1'b0;
					end
				end
				default: ar_st <= AR_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// timecode counter
	// ----------------------------------------
	reg  [2:0]  mode_q;
	reg         boot;
	reg  [21:0] next_tc;
	reg         next_frame;
	wire        recording = rec_running || auto_rec;
	wire        cal_entry = mode == `TCM_MODE_CAL && mode_q != `TCM_MODE_CAL;
	wire        manual_ok = mode == `TCM_MODE_FREE || mode == `TCM_MODE_RECG;

	always @*
	begin
		next_tc = tc_out;
		next_frame = 1'b0;
		case (mode)
			`TCM_MODE_FREE, `TCM_MODE_RECG:
			begin
				if (do_preset) // R04
					next_tc = preset;
				else if (do_reload)
					next_tc = ext_last;
				else if (tick && (mode == `TCM_MODE_FREE || recording)) // R03 R05 R06
				begin
					next_tc = tc_adv(tc_out, fps, dropf);
					next_frame = 1'b1;
				end
			end
			`TCM_MODE_CAL:
			begin
				if (boot || rtc_changed || cal_entry) // R07
					next_tc = rtc_tc;
				else if (tick)
				begin
					next_tc = tc_adv(tc_out, fps, dropf);
					next_frame = 1'b1;
				end
			end
			`TCM_MODE_CHASE, `TCM_MODE_AUTO:
			begin
				if (ext_valid) // R08
				begin
					next_tc = ext_tc;
					next_frame = 1'b1;
				end
				else if (!ext_present && hold_ok && tick) // R16
				begin
					next_tc = tc_adv(tc_out, fps, dropf);
					next_frame = 1'b1;
				end
			end
			default: next_tc = tc_out;
		endcase
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tc_out <= 22'h000000;
			tc_frame <= 1'b0;
			mode_q <= `TCM_MODE_OFF;
			boot <= 1'b1;
		end
		else
		begin
			tc_out <= next_tc;
			tc_frame <= next_frame; // R01
			mode_q <= mode;
			if (mode == `TCM_MODE_CAL)
				boot <= 1'b0;
		end
	end

	// ----------------------------------------
	// output gating and audio clock
	// ----------------------------------------
	reg next_en;

	always @*
	begin
		case (mode)
			`TCM_MODE_OFF:   next_en = 1'b0; // R02
			`TCM_MODE_CHASE,
			`TCM_MODE_AUTO:  next_en = ext_present || hold_ok;
			default:         next_en = !mute_ok || recording || rec_paused; // R11 R12
		endcase
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tc_out_en <= 1'b0;
			tc_embed <= 1'b0;
			audio_clk_ext <= 1'b0;
		end
		else
		begin
			tc_out_en <= next_en;
			tc_embed <= mode != `TCM_MODE_OFF; // R02
			// without code the audio clock stays internal for continuity
			audio_clk_ext <= lock_ok && ext_present; // R14 R15
		end
	end

	assign stat = {2'h0, manual_ok, recording, audio_clk_ext, tc_out_en, auto_rec, ext_present};
endmodule
`default_nettype wire

// [tcm_ctrl_properties.sv]
`include "tcm_defines.vh"
`default_nettype none
module tcm_ctrl_properties #(
	parameter TENTH_CYC = 10
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        ext_valid,
	input wire logic [21:0] ext_tc,
	input wire logic        rec_running,
	input wire logic        rec_paused,
	input wire logic [21:0] tc_out,
	input wire logic        tc_out_en,
	input wire logic        tc_frame,
	input wire logic        tc_embed,
	input wire logic        auto_rec,
	input wire logic        audio_clk_ext
);
	// ----------------------------------------
	// shadow of the control word, updated at end of data phase
	// ----------------------------------------
	logic [10:0] ctrl;
	logic        wp, cp, cw;
	wire         tk   = hsel && htrans[1] && hready && hwrite;
	wire  [2:0]  m    = ctrl[2:0];
	wire         chs  = (m == `TCM_MODE_CHASE) || (m == `TCM_MODE_AUTO);
	wire         mute = ctrl[`TCM_CTRL_MUTE];
	wire         intm = (m == `TCM_MODE_FREE) || (m == `TCM_MODE_RECG) || (m == `TCM_MODE_CAL);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wp   <= 1'b0;
			cp   <= 1'b0;
			cw   <= 1'b0;
			ctrl <= `TCM_CTRL_RST;
		end
		else
		begin
			wp <= tk && (haddr[7:0] == `TCM_OFS_CTRL);
			cp <= tk && (haddr[7:0] == `TCM_OFS_CMD);
			cw <= cp;
			if (wp)
				ctrl <= hwdata[10:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_off_quiet;
		(m == `TCM_MODE_OFF) [*3] |-> !tc_out_en && !tc_embed;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("code active in off mode");
	property p_embed;
		(m != `TCM_MODE_OFF) [*3] |-> tc_embed;
	endproperty
	a_embed: assert property (p_embed)
		else $error("code not embedded while mode is on");
	property p_free_out;
		(m == `TCM_MODE_FREE && !mute) [*3] |-> tc_out_en;
	endproperty
	a_free_out: assert property (p_free_out)
		else $error("free run without output");
	property p_follow;
		chs && ext_valid |=> tc_out == $past(ext_tc) && tc_frame;
	endproperty
	a_follow: assert property (p_follow)
		else $error("chase did not take received word");
	property p_auto_only;
		(m != `TCM_MODE_AUTO) [*3] |-> !auto_rec;
	endproperty
	a_auto_only: assert property (p_auto_only)
		else $error("auto record outside auto mode");
	property p_lock_only;
		!(chs && ctrl[`TCM_CTRL_CLKLOCK]) [*3] |-> !audio_clk_ext;
	endproperty
	a_lock_only: assert property (p_lock_only)
		else $error("audio clock locked outside chase");
	property p_mute_idle;
		(mute && intm && !rec_running && !rec_paused) [*3] |-> !tc_out_en;
	endproperty
	a_mute_idle: assert property (p_mute_idle)
		else $error("code driven while stopped and muted");
	property p_mute_pause;
		(mute && m == `TCM_MODE_FREE && rec_paused) [*3] |-> tc_out_en;
	endproperty
	a_mute_pause: assert property (p_mute_pause)
		else $error("code dropped while paused");
	property p_recg_hold;
		(m == `TCM_MODE_RECG && !rec_running && !cp && !cw) [*3] |-> $stable(tc_out);
	endproperty
	a_recg_hold: assert property (p_recg_hold)
		else $error("record run counter moved while idle");
	c_follow: cover property (chs && ext_valid);
	c_auto: cover property ($rose(auto_rec));
	c_mute: cover property (mute && intm && rec_paused);
endmodule
bind tcm_ctrl tcm_ctrl_properties #(.TENTH_CYC(TENTH_CYC)) i_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .ext_valid(ext_valid),
	.ext_tc(ext_tc), .rec_running(rec_running), .rec_paused(rec_paused), .tc_out(tc_out),
	.tc_out_en(tc_out_en), .tc_frame(tc_frame), .tc_embed(tc_embed), .auto_rec(auto_rec),
	.audio_clk_ext(audio_clk_ext)
);
`default_nettype wire

// [tcm_ctrl_tb_top.sv]
`include "tcm_defines.vh"
`default_nettype none
module tcm_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        hclk, hresetn, hsel, hwrite, rtc_changed, rec_running, rec_paused, fire;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [21:0] ext_tc, rtc_tc, tc_out, word;
	logic        hreadyout, hresp, ext_valid, tc_out_en, tc_frame, tc_embed;
	logic        auto_rec, audio_clk_ext;
	int          checked, bad_count, cyc, n;
	tcm_ctrl #(.TENTH_CYC(10)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_valid(ext_valid),
		.ext_tc(ext_tc), .rtc_tc(rtc_tc), .rtc_changed(rtc_changed),
		.rec_running(rec_running), .rec_paused(rec_paused), .tc_out(tc_out),
		.tc_out_en(tc_out_en), .tc_frame(tc_frame), .tc_embed(tc_embed),
		.auto_rec(auto_rec), .audio_clk_ext(audio_clk_ext)
	);
	tcm_src i_src (
		.hclk(hclk), .hresetn(hresetn), .fire(fire), .word(word),
		.ext_valid(ext_valid), .ext_tc(ext_tc)
	);
	always #5 hclk = ~hclk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h00000000, q);
		chk(nm, e, q);
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge hclk);
		#1;
	endtask
	task automatic frame(input logic [21:0] w);
		@(posedge hclk);
		fire <= 1'b1;
		word <= w;
		@(posedge hclk);
		fire <= 1'b0;
	endtask
	task automatic do_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_off;
		rdc("ctrl", `TCM_OFS_CTRL, 32'h00000000);
		rdc("delay", `TCM_OFS_DELAY, 32'h00000000);
		wr(8'h20, 32'hFFFFFFFF);
		rdc("unmapped", 8'h20, 32'h00000000);
		chk("hresp", 32'h0, 32'(hresp));
		frame(22'h000123);
		wt(3);
		chk("off out", 32'h0, 32'(tc_out_en));
		chk("off embed", 32'h0, 32'(tc_embed));
		rdc("status off", `TCM_OFS_STATUS, 32'h00000001);
	endtask
	task automatic t_free;
		for (int r = 0; r < 7; r++)
		begin
			wr(`TCM_OFS_CTRL, (r << 4) | 1);
			rdc("rate", `TCM_OFS_CTRL, (r << 4) | 1);
		end
		wr(`TCM_OFS_CTRL, 32'h00000001);
		wt(3);
		chk("free out", 32'h1, 32'(tc_out_en));
		chk("free embed", 32'h1, 32'(tc_embed));
		wr(`TCM_OFS_PRESET, 32'h00021064);
		wr(`TCM_OFS_CMD, 32'h00000001);
		wt(2);
		chk("preset", 32'h00021064, 32'(tc_out));
		rdc("tc reg", `TCM_OFS_TC, 32'h00021064);
		wr(`TCM_OFS_CTRL, 32'h00000301);
		wt(3);
		chk("mute idle", 32'h0, 32'(tc_out_en));
		chk("lock free", 32'h0, 32'(audio_clk_ext));
		@(posedge hclk);
		rec_paused <= 1'b1;
		wt(3);
		chk("mute pause", 32'h1, 32'(tc_out_en));
		@(posedge hclk);
		rec_paused  <= 1'b0;
		rec_running <= 1'b1;
		wt(3);
		chk("mute rec", 32'h1, 32'(tc_out_en));
		@(posedge hclk);
		rec_running <= 1'b0;
	endtask
	task automatic t_recg_cal;
		wr(`TCM_OFS_CTRL, 32'h00000002);
		wt(3);
		chk("recg freeze", 32'h00021064, 32'(tc_out));
		frame(22'h000A0B);
		wt(3);
		chk("recg ignore ext", 32'h00021064, 32'(tc_out));
		wr(`TCM_OFS_CMD, 32'h00000002);
		wt(2);
		chk("reload", 32'h00000A0B, 32'(tc_out));
		@(posedge hclk);
		rtc_tc <= 22'h040821;
		wr(`TCM_OFS_CTRL, 32'h00000003);
		wt(3);
		chk("cal entry", 32'h00040821, 32'(tc_out));
		@(posedge hclk);
		rtc_tc      <= 22'h060000;
		rtc_changed <= 1'b1;
		@(posedge hclk);
		rtc_changed <= 1'b0;
		wt(3);
		chk("cal change", 32'h00060000, 32'(tc_out));
		chk("cal out", 32'h1, 32'(tc_out_en));
	endtask
	task automatic t_chase;
		wr(`TCM_OFS_CTRL, 32'h00000304);
		frame(22'h001F2A);
		wt(2);
		chk("chase", 32'h00001F2A, 32'(tc_out));
		chk("mute chase", 32'h1, 32'(tc_out_en));
		chk("lock", 32'h1, 32'(audio_clk_ext));
		wr(`TCM_OFS_PRESET, 32'h00000055);
		wr(`TCM_OFS_CMD, 32'h00000001);
		wt(2);
		chk("chase no load", 32'h00001F2A, 32'(tc_out));
		rdc("status chase", `TCM_OFS_STATUS, 32'h0000000D);
	endtask
	task automatic t_auto;
		do_reset();
		wr(`TCM_OFS_DELAY, 32'h0000007F);
		rdc("delay clamp", `TCM_OFS_DELAY, 32'h00000050);
		wr(`TCM_OFS_DELAY, 32'h00000003);
		wr(`TCM_OFS_CTRL, 32'h00000605);
		wt(5);
		chk("auto idle", 32'h0, 32'(auto_rec));
		chk("lock fallback", 32'h0, 32'(audio_clk_ext));
		chk("holdover out", 32'h1, 32'(tc_out_en));
		frame(22'h000100);
		n = 0;
		while (auto_rec !== 1'b1 && n < 100)
		begin
			wt(1);
			n++;
		end
		// three tenths at ten cycles each, a few cycles of pipeline allowed
		chk("auto delay", 32'h1, 32'(n >= 27 && n <= 34));
		chk("lock auto", 32'h1, 32'(audio_clk_ext));
		wr(`TCM_OFS_CTRL, 32'h00000001);
		wt(3);
		chk("auto leave", 32'h0, 32'(auto_rec));
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			summarize();
		end
	end
	initial
	begin
		hclk        = 1'b0;
		hresetn     = 1'b0;
		hsel        = 1'b0;
		hwrite      = 1'b0;
		haddr       = 32'h00000000;
		hwdata      = 32'h00000000;
		htrans      = 2'b00;
		hsize       = 3'b010;
		rtc_tc      = 22'h000000;
		rtc_changed = 1'b0;
		rec_running = 1'b0;
		rec_paused  = 1'b0;
		fire        = 1'b0;
		word        = 22'h000000;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_off();
		t_free();
		t_recg_cal();
		t_chase();
		t_auto();
		summarize();
	end
endmodule
`default_nettype wire

// [tcm_defines.vh]
`ifndef TCM_DEFINES_VH
`define TCM_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TCM_OFS_CTRL   8'h00
`define TCM_OFS_DELAY  8'h04
`define TCM_OFS_PRESET 8'h08
`define TCM_OFS_CMD    8'h0C
`define TCM_OFS_STATUS 8'h10
`define TCM_OFS_TC     8'h14
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define TCM_CTRL_MODE_LSB 0
`define TCM_CTRL_RATE_LSB 4
`define TCM_CTRL_MUTE     8
`define TCM_CTRL_CLKLOCK  9
`define TCM_CTRL_HOLD     10
`define TCM_CTRL_RST      11'h000
`define TCM_DELAY_RST     7'h00
`define TCM_DELAY_MAX     7'h50
`define TCM_CMD_PRESET    0
`define TCM_CMD_RELOAD    1
// ----------------------------------------
// modes
// ----------------------------------------
`define TCM_MODE_OFF   3'h0
`define TCM_MODE_FREE  3'h1
`define TCM_MODE_RECG  3'h2
`define TCM_MODE_CAL   3'h3
`define TCM_MODE_CHASE 3'h4
`define TCM_MODE_AUTO  3'h5
// ----------------------------------------
// frame rates
// ----------------------------------------
`define TCM_RATE_23976 3'h0
`define TCM_RATE_24    3'h1
`define TCM_RATE_25    3'h2
`define TCM_RATE_2997  3'h3
`define TCM_RATE_2997D 3'h4
`define TCM_RATE_30    3'h5
`define TCM_RATE_30D   3'h6
// ----------------------------------------
// timecode word layout
// ----------------------------------------
`define TCM_FF_LSB 0
`define TCM_SS_LSB 5
`define TCM_MM_LSB 11
`define TCM_HH_LSB 17
// ----------------------------------------
// timing
// ----------------------------------------
`define TCM_CLK_NS    10
`define TCM_TENTH_NS  100000000
`define TCM_ACC_MOD   (38'h5F5E100 * 38'h3E9)
`define TCM_MUL_INT   38'h3E9
`define TCM_MUL_PULL  38'h3E8
`define TCM_LOSS_TICKS 2'h2
`endif

// [tcm_src.sv]
`include "tcm_defines.vh"
`default_nettype none
// ----------------------------------------
// external code source: one decoded frame word per request
// ----------------------------------------
module tcm_src (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        fire,
	input  wire logic [21:0] word,
	output var  logic        ext_valid,
	output var  logic [21:0] ext_tc
);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_valid <= 1'b0;
			ext_tc    <= 22'h000000;
		end
		else
		begin
			ext_valid <= fire;
			// between frames the word toggles so stale data never looks valid
			ext_tc    <= fire ? word : ~ext_tc;
		end
	end
endmodule
`default_nettype wire
